//--- port_b_pkg.sv
// Package: register map, field layout and timing constants for output port B
package port_b_pkg;

	// ----------------------------------------------------------------
	// Register offsets and widths
	// ----------------------------------------------------------------
	localparam logic [7:0] parallel_out_b_control_addr = 8'h1C;
	localparam logic [7:0] link_out_b_control_addr     = 8'h1D;
	localparam logic [7:0] port_clock_control_addr     = 8'h1E;
	localparam logic [5:0] parallel_out_b_reset        = 6'h00;
	localparam logic [7:0] link_out_b_reset            = 8'h00;
	localparam logic [2:0] port_clock_reset            = 3'h0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int par_src_bit   = 0;
	localparam int par_sel_lo    = 1;
	localparam int par_fmt_bit   = 5;
	localparam int link_src_bit  = 0;
	localparam int link_mode_bit = 1;
	localparam int link_rssi_bit = 2;
	localparam int link_dly_lo   = 3;
	localparam int link_en_bit   = 7;
	localparam int pclk_int_bit  = 0;
	localparam int pclk_div_lo   = 1;

	// ----------------------------------------------------------------
	// Sources and timing
	// ----------------------------------------------------------------
	localparam logic [2:0] src_loop_a  = 3'h4;
	localparam logic [2:0] src_loop_b  = 3'h5;
	localparam logic [3:0] link_dly_min = 4'h6;
	localparam logic [3:0] link_iq_len  = 4'h4;
	localparam logic [3:0] link_rec_len = 4'h8;

	typedef struct packed {
		logic [15:0] i;
		logic [15:0] q;
		logic [15:0] gain;
	} sample_t;

	typedef struct packed {
		logic [15:0] data;
		logic [2:0]  chan;
		logic        iq;
		logic        valid;
	} par_word_t;

endpackage

//--- port_clock_gen.sv
// Port clock tick generator: internal divider or external pin edge
`timescale 1ns/1ps
`default_nettype none
module port_clock_gen import port_b_pkg::*; (
	input  wire logic       clk,      // Device clock
	input  wire logic       sys_rst,  // Synchronous reset, active high
	input  wire logic       int_sel,  // 1: derive port clock internally
	input  wire logic [1:0] div_code, // 00 /1, 01 /2, 10 /4, 11 /8
	input  wire logic       pclk_in,  // Port clock pin input
	output logic            tick,     // One-cycle port clock enable
	output logic            pclk_out, // Port clock pin output
	output logic            pclk_oe   // High while driving the pin
);
	logic [2:0] div_cnt;
	logic [2:0] div_max;
	logic       pclk_in_q;

	assign div_max = 3'((4'h1 << div_code) - 4'h1);

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst || !int_sel || div_cnt >= div_max) begin
			div_cnt <= 3'h0;
		end else begin
			div_cnt <= div_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pclk_in_q <= 1'b0;
			tick      <= 1'b0;
			pclk_out  <= 1'b0;
			pclk_oe   <= 1'b0;
		end else begin
			pclk_in_q <= pclk_in;
			pclk_oe   <= int_sel;
			if (int_sel) begin
				tick <= (div_cnt >= div_max);
				// Pin shows one edge per tick; divide-by-1 limited to clk/2
				if (div_cnt >= div_max) begin
					pclk_out <= ~pclk_out;
				end
			end else begin
				tick     <= pclk_in && !pclk_in_q;
				pclk_out <= 1'b0;
			end
		end
	end

	property p_div_spacing;
		@(posedge clk) disable iff (sys_rst)
		(int_sel && $stable(int_sel) && $stable(div_code) && div_code == 2'h1
			&& tick) |=> !tick ##1 (tick || !int_sel || $changed(div_code));
	endproperty
	a_div_spacing: assert property (p_div_spacing)
		else $error("port clock divide by two spacing wrong");
endmodule
`default_nettype wire

//--- output_port_b.sv
// Output port B: parallel and link output paths with port clock control
// Notes on behaviour
// - link enable bit clear disables link port; data goes out the parallel port.
// - parallel bit 0 selects channel data or gain loop data as source.
// - gain mode: bit 1 admits loop A, bit 2 admits loop B on parallel.
// - channel mode: bits 1 to 4 enable channels 0 to 3 on parallel port.
// - words leave in trigger arrival order, tagged with the source channel.
// - format bit clear: I then Q as 16-bit words, IQ flag marks I.
// - format bit set: 8-bit I and Q together, IQ flags held high.
// - link bit 0 selects channel data or gain loop data for the link.
// - link channel mode: bit 1 set cycles channels 0-3, clear alternates 0,1.
// - link gain mode bit 1 set sends loop B IQ plus gain words.
// - link bit 0 set with bit 1 clear alternates loops A and B; bit 2 drops gain.
// - gain word is zero padded to four bytes to fill quad-words.
// - link channel mode ignores the gain word bit.
// - link bits 6-3 set delay from receiver ready to first byte.
// - start delay never below six port clock cycles.
// - port clock bit 0 set derives port clock internally and drives pin.
// - port clock bits 2:1 divide device clock by 1, 2, 4 or 8.
`timescale 1ns/1ps
`default_nettype none
module output_port_b import port_b_pkg::*; (
	input  wire logic            clk,          // Device clock, 10 MHz
	input  wire logic            sys_rst,      // Synchronous reset
	input  wire logic [7:0]      reg_addr,     // Internal register address
	input  wire logic [7:0]      reg_wdata,    // Write data
	input  wire logic            reg_wr,       // Write strobe
	input  wire logic            reg_rd,       // Read strobe
	output logic [7:0]           reg_rdata,    // Read data, next cycle
	input  wire logic [3:0]      chan_valid,   // Channel filter output triggers
	input  wire sample_t [3:0]   chan_sample,  // Channel IQ samples
	input  wire logic [1:0]      loop_valid,   // Gain loop A/B triggers
	input  wire sample_t [1:0]   loop_sample,  // Gain loop IQ and gain
	output logic                 src_busy,     // Holding word occupied
	output par_word_t            par_out,      // Parallel port B word
	input  wire logic            link_ready,   // Receiver data ready
	output logic [7:0]           link_data,    // Link byte
	output logic                 link_valid,   // Link byte strobe
	input  wire logic            pclk_in,      // Port clock pin input
	output logic                 pclk_out,     // Port clock pin output
	output logic                 pclk_oe       // Port clock pin enable
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [5:0] parallel_out_b_control;
	logic [7:0] link_out_b_control;
	logic [2:0] port_clock_control;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			parallel_out_b_control <= parallel_out_b_reset;
			link_out_b_control     <= link_out_b_reset;
			port_clock_control     <= port_clock_reset;
		end else if (reg_wr) begin
			case (reg_addr)
				parallel_out_b_control_addr: begin
					parallel_out_b_control <= reg_wdata[5:0];
				end
				link_out_b_control_addr: begin
					link_out_b_control <= reg_wdata;
				end
				port_clock_control_addr: begin
					port_clock_control <= reg_wdata[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				parallel_out_b_control_addr: begin
					reg_rdata <= {2'h0, parallel_out_b_control};
				end
				link_out_b_control_addr: begin
					reg_rdata <= link_out_b_control;
				end
				port_clock_control_addr: begin
					reg_rdata <= {5'h00, port_clock_control};
				end
				default: begin
					reg_rdata <= 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Decoded controls
	// ----------------------------------------------------------------
	logic       link_en;
	logic       par_gain;
	logic       par_fmt8;
	logic       link_gain;
	logic       link_four;
	logic       link_words;
	logic [3:0] link_dly;
	logic       tick;

	assign link_en   = link_out_b_control[link_en_bit];
	assign par_gain  = parallel_out_b_control[par_src_bit];
	assign par_fmt8  = parallel_out_b_control[par_fmt_bit];
	assign link_gain = link_out_b_control[link_src_bit];
	assign link_four = link_out_b_control[link_mode_bit];
	// Gain words only exist in gain mode; the bit is moot otherwise
	assign link_words = link_gain
		&& !link_out_b_control[link_rssi_bit];
	// Short settings are raised so the receiver always gets its margin
	assign link_dly = (link_out_b_control[6:3] < link_dly_min)
		? link_dly_min : link_out_b_control[6:3];

	port_clock_gen u_pclk (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.int_sel  (port_clock_control[pclk_int_bit]),
		.div_code (port_clock_control[pclk_div_lo +: 2]),
		.pclk_in  (pclk_in),
		.tick     (tick),
		.pclk_out (pclk_out),
		.pclk_oe  (pclk_oe)
	);

	// ----------------------------------------------------------------
	// Source admission
	// ----------------------------------------------------------------
	logic [1:0] link_ptr;
	logic [5:0] enable_mask;
	logic [5:0] trig;
	logic [5:0] take;
	logic [2:0] take_idx;
	sample_t    take_sample;
	sample_t    held;
	logic [2:0] held_src;
	logic       held_full;
	logic       release_word;

	assign trig = {loop_valid, chan_valid};

	always_comb begin
		enable_mask = 6'h00;
		if (!link_en) begin
			if (par_gain) begin
				enable_mask = {parallel_out_b_control[2],
					parallel_out_b_control[1], 4'h0};
			end else begin
				enable_mask = {2'h0, parallel_out_b_control[4:1]};
			end
		end else if (!link_gain) begin
			enable_mask = 6'(6'h01 << link_ptr);
		end else if (link_four) begin
			enable_mask = 6'h20;
		end else begin
			enable_mask = link_ptr[0] ? 6'h20 : 6'h10;
		end
	end

	// One word is held at a time; a trigger arriving while busy is lost
	// unless the source waits on src_busy
	always_comb begin
		take        = trig & enable_mask & {6{!held_full}};
		take_idx    = 3'h0;
		take_sample = chan_sample[0];
		for (int k = 5; k >= 0; k--) begin
			if (take[k]) begin
				take_idx    = 3'(k);
				take_sample = (k >= 4) ? loop_sample[k[0]] : chan_sample[k[1:0]];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			held_full <= 1'b0;
			held_src  <= 3'h0;
			held      <= '0;
		end else if (!held_full && take != 6'h00) begin
			held_full <= 1'b1;
			held_src  <= take_idx;
			held      <= take_sample;
		end else if (release_word) begin
			held_full <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			src_busy <= 1'b0;
		end else begin
			src_busy <= held_full;
		end
	end

	// ----------------------------------------------------------------
	// Parallel path
	// ----------------------------------------------------------------
	logic par_phase;
	logic par_done;

	assign par_done = !link_en && held_full && tick && (par_fmt8 || par_phase);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			par_out   <= '0;
			par_phase <= 1'b0;
		end else if (link_en) begin
			par_out   <= '0;
			par_phase <= 1'b0;
		end else if (held_full && tick) begin
			par_out.valid <= 1'b1;
			par_out.chan  <= held_src;
			if (par_fmt8) begin
				par_out.data <= {held.i[15:8], held.q[15:8]};
				par_out.iq   <= 1'b1;
			end else begin
				par_out.data <= par_phase ? held.q : held.i;
				par_out.iq   <= !par_phase;
				par_phase    <= !par_phase;
			end
		end else begin
			par_out.valid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Link path
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		link_idle  = 3'b001,
		link_delay = 3'b010,
		link_send  = 3'b100
	} link_state_t;

	link_state_t link_state;
	logic [3:0]  dly_cnt;
	logic [3:0]  byte_idx;
	logic [3:0]  rec_len;
	logic [7:0]  rec_bytes [8];
	logic        link_done;

	assign rec_len = link_words ? link_rec_len : link_iq_len;
	assign rec_bytes[0] = held.i[15:8];
	assign rec_bytes[1] = held.i[7:0];
	assign rec_bytes[2] = held.q[15:8];
	assign rec_bytes[3] = held.q[7:0];
	assign rec_bytes[4] = held.gain[15:8];
	assign rec_bytes[5] = held.gain[7:0];
	assign rec_bytes[6] = 8'h00;
	assign rec_bytes[7] = 8'h00;
	assign link_done = link_state == link_send && tick
		&& byte_idx == rec_len - 4'h1;
	assign release_word = par_done || link_done;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link_state <= link_idle;
			dly_cnt    <= 4'h0;
			byte_idx   <= 4'h0;
			link_data  <= 8'h00;
			link_valid <= 1'b0;
		end else begin
			link_valid <= 1'b0;
			case (link_state)
				link_idle: begin
					if (link_en && held_full && link_ready) begin
						link_state <= link_delay;
						dly_cnt    <= link_dly;
					end
				end
				link_delay: begin
					if (tick) begin
						if (dly_cnt == 4'h1) begin
							link_state <= link_send;
							byte_idx   <= 4'h0;
						end else begin
							dly_cnt <= dly_cnt - 4'h1;
						end
					end
				end
				link_send: begin
					if (tick) begin
						link_valid <= 1'b1;
						link_data  <= rec_bytes[byte_idx[2:0]];
						byte_idx   <= byte_idx + 4'h1;
						if (link_done) begin
							link_state <= link_idle;
						end
					end
				end
				default: begin
					link_state <= link_idle;
				end
			endcase
		end
	end

	// Channel and loop sequencing pointer
	always_ff @(posedge clk) begin
		if (sys_rst || !link_en) begin
			link_ptr <= 2'h0;
		end else if (link_done) begin
			if (!link_gain && !link_four) begin
				link_ptr <= {1'b0, ~link_ptr[0]};
			end else begin
				link_ptr <= link_ptr + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [4:0] dly_ticks;

	always_ff @(posedge clk) begin
		if (sys_rst || link_state != link_delay) begin
			dly_ticks <= 5'h00;
		end else if (tick) begin
			dly_ticks <= dly_ticks + 5'h01;
		end
	end

	property p_par_quiet;
		@(posedge clk) disable iff (sys_rst)
		link_en |=> !par_out.valid;
	endproperty
	a_par_quiet: assert property (p_par_quiet)
		else $error("parallel port active while link enabled");

	property p_fmt8_iq;
		@(posedge clk) disable iff (sys_rst)
		(!link_en && par_fmt8 && held_full && tick) |=>
			(par_out.valid && par_out.iq);
	endproperty
	a_fmt8_iq: assert property (p_fmt8_iq)
		else $error("eight-bit format without IQ high");

	property p_fmt16_order;
		@(posedge clk) disable iff (sys_rst)
		(!link_en && !par_fmt8 && par_out.valid && par_out.iq && held_full
			&& tick && $stable(parallel_out_b_control))
			|=> (par_out.valid && !par_out.iq);
	endproperty
	a_fmt16_order: assert property (p_fmt16_order)
		else $error("Q word does not follow I word");

	property p_par_src;
		@(posedge clk) disable iff (sys_rst)
		(!link_en && !held_full && take != 6'h00 && par_gain) |=>
			(held_src == src_loop_a || held_src == src_loop_b);
	endproperty
	a_par_src: assert property (p_par_src)
		else $error("channel word admitted in gain mode");

	property p_min_delay;
		@(posedge clk) disable iff (sys_rst)
		(link_state == link_delay && tick && dly_cnt == 4'h1) |->
			(dly_ticks >= 5'(link_dly_min) - 5'h01);
	endproperty
	a_min_delay: assert property (p_min_delay)
		else $error("link start delay below six ticks");

	property p_pad_zero;
		@(posedge clk) disable iff (sys_rst)
		(link_state == link_send && tick && byte_idx >= 4'h6) |=>
			(link_valid && link_data == 8'h00);
	endproperty
	a_pad_zero: assert property (p_pad_zero)
		else $error("gain word padding not zero");

	property p_chan_len;
		@(posedge clk) disable iff (sys_rst)
		(link_state == link_send && !link_gain) |-> byte_idx < link_iq_len;
	endproperty
	a_chan_len: assert property (p_chan_len)
		else $error("channel record longer than four bytes");

	property p_pclk_oe;
		@(posedge clk) disable iff (sys_rst)
		$rose(port_clock_control[pclk_int_bit]) |=> pclk_oe;
	endproperty
	a_pclk_oe: assert property (p_pclk_oe)
		else $error("port clock pin not driven in internal mode");

	property p_two_chan;
		@(posedge clk) disable iff (sys_rst)
		(link_en && !link_gain && !link_four && held_full
			&& $rose(held_full)) |-> held_src[2:1] == 2'h0;
	endproperty
	a_two_chan: assert property (p_two_chan)
		else $error("two-channel link mode admitted channel 2 or 3");
endmodule
`default_nettype wire

//--- link_receiver_model.sv
// Far-side model: link receiver and external port clock source
`timescale 1ns/1ps
`default_nettype none
module link_receiver_model (
	input  wire logic        clk,        // Device clock
	input  wire logic        sys_rst,    // Synchronous reset
	input  wire logic        accept,     // Bench lets the receiver take data
	input  wire logic        ext_clk_en, // Run the external port clock
	input  wire logic [7:0]  link_data,  // Link byte
	input  wire logic        link_valid, // Link byte strobe
	output logic             link_ready, // Receiver data ready, level
	output logic             pclk_drv,   // External port clock drive
	output logic [63:0]      rx,         // Bytes taken, newest lowest
	output logic [3:0]       rx_count,   // Bytes taken
	output logic [7:0]       gap         // Ready cycles before first byte
);
	logic [1:0] div_cnt;

	// Dropping ready also clears the capture for the next frame
	always_ff @(posedge clk) begin
		if (sys_rst || !accept) begin
			link_ready <= 1'b0;
			rx <= '0;
			rx_count <= '0;
			gap <= '0;
		end else begin
			link_ready <= 1'b1;
			if (link_valid) begin
				rx <= {rx[55:0], link_data};
				rx_count <= rx_count + 4'h1;
			end else if (link_ready && rx_count == 4'h0) begin
				gap <= gap + 8'h01;
			end
		end
	end

	// Clock stands low while not asked for, so no stray ticks
	always_ff @(posedge clk) begin
		if (sys_rst || !ext_clk_en) begin
			div_cnt <= '0;
			pclk_drv <= 1'b0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
			if (div_cnt[0]) pclk_drv <= ~pclk_drv;
		end
	end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for output port B
`timescale 1ns/1ps
`default_nettype none
module tb import port_b_pkg::*;;
	typedef struct {
		logic [5:0] pc;
		logic [1:0] dv;
		bit         ext;
		int         s;
		bit         on;
	} row_t;

	logic          clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
	logic          accept = 0, ext_on = 0;
	logic [7:0]    reg_addr = '0, reg_wdata = '0, reg_rdata, link_data;
	logic [3:0]    chan_valid = '0, rx_count;
	logic [1:0]    loop_valid = '0;
	sample_t [3:0] chan_sample;
	sample_t [1:0] loop_sample;
	par_word_t     par_out;
	logic          src_busy, link_ready, link_valid, pclk_out, pclk_oe;
	logic          pclk_drv;
	logic [63:0]   rx;
	logic [7:0]    gap;
	int            errors = 0, checks_done = 0;
	wire logic     pclk_pin = pclk_oe ? pclk_out : pclk_drv;

	row_t rows [11] = '{
		'{6'h02, 2'h0, 0, 0, 1}, '{6'h04, 2'h1, 0, 1, 1},
		'{6'h08, 2'h2, 0, 2, 1}, '{6'h10, 2'h3, 0, 3, 1},
		'{6'h1C, 2'h0, 0, 0, 0}, '{6'h03, 2'h0, 0, 4, 1},
		'{6'h05, 2'h1, 0, 5, 1}, '{6'h03, 2'h0, 0, 5, 0},
		'{6'h22, 2'h0, 0, 0, 1}, '{6'h25, 2'h0, 0, 5, 1},
		'{6'h02, 2'h0, 1, 0, 1}
	};

	always #50 clk = ~clk;

	output_port_b output_port_b_i (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_valid(chan_valid),
		.chan_sample(chan_sample), .loop_valid(loop_valid),
		.loop_sample(loop_sample), .src_busy(src_busy), .par_out(par_out),
		.link_ready(link_ready), .link_data(link_data),
		.link_valid(link_valid), .pclk_in(pclk_pin), .pclk_out(pclk_out),
		.pclk_oe(pclk_oe));

	link_receiver_model link_receiver_model_i (.clk(clk),
		.sys_rst(sys_rst), .accept(accept), .ext_clk_en(ext_on),
		.link_data(link_data), .link_valid(link_valid),
		.link_ready(link_ready), .pclk_drv(pclk_drv), .rx(rx),
		.rx_count(rx_count), .gap(gap));

	function automatic sample_t samp(input int k);
		samp.i = {k[3:0], 12'h1A5};
		samp.q = {k[3:0], 12'h2B6};
		samp.gain = {k[3:0], 12'h3C7};
	endfunction

	task automatic check(input string what, input logic [63:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		check("reg", reg_rdata, exp);
	endtask

	// Codes 0-3 are channels, 4 and 5 the gain loops
	task automatic fire(input int s);
		@(negedge clk);
		if (s < 4) chan_valid[s] = 1'b1;
		else loop_valid[s-4] = 1'b1;
		@(negedge clk);
		chan_valid = '0;
		loop_valid = '0;
	endtask

	task automatic par_case(input row_t r);
		int t, n, tg, lo;
		logic pp, busy;
		int at [2];
		par_word_t w [2];
		sample_t e;
		e = samp(r.s);
		n = 0;
		tg = 0;
		lo = 39 >> r.dv;
		ext_on = r.ext;
		wr(8'h1E, {5'h00, r.dv, ~r.ext});
		wr(8'h1C, {2'h0, r.pc});
		fire(r.s);
		for (t = 0; t < 40; t++) begin
			if (t == 1) busy = src_busy;
			if (t > 0 && pclk_out !== pp) tg++;
			pp = pclk_out;
			if (par_out.valid === 1'b1) begin
				if (n < 2) w[n] = par_out;
				if (n < 2) at[n] = t;
				n++;
			end
			@(negedge clk);
		end
		check("pclk_oe", pclk_oe, !r.ext);
		check("busy", busy, r.on);
		check("pclk", r.ext ? tg == 0 : tg >= lo && tg <= lo + 1, 1);
		if (!r.on) check("words", n, 0);
		else if (r.pc[5]) begin
			check("words", n, 1);
			check("word", w[0], {e.i[15:8], e.q[15:8], r.s[2:0], 2'b11});
		end else begin
			check("words", n, 2);
			check("i word", w[0], {e.i, r.s[2:0], 2'b11});
			check("q word", w[1], {e.q, r.s[2:0], 2'b01});
			check("gap", at[1] - at[0], r.ext ? 4 : 1 << r.dv);
		end
	endtask

	task automatic link_case(input logic [7:0] lc, input int s, nb);
		int t, lo;
		sample_t e;
		e = samp(s);
		lo = (lc[6:3] < 6) ? 6 : lc[6:3];
		wr(8'h1D, lc);
		fire(s);
		accept = 1'b1;
		for (t = 0; t < 50; t++) begin
			@(negedge clk);
			check("par idle", par_out, '0);
		end
		check("bytes", rx_count, nb);
		if (nb == 4) check("iq", rx[31:0], {e.i, e.q});
		if (nb == 8) check("rec", rx, {e.i, e.q, e.gain, 16'h0000});
		if (nb > 0) check("delay", gap >= lo && gap <= lo + 4, 1);
		accept = 1'b0;
		@(negedge clk);
	endtask

	initial begin
		for (int k = 0; k < 4; k++) chan_sample[k] = samp(k);
		for (int k = 0; k < 2; k++) loop_sample[k] = samp(k + 4);
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		foreach (rows[r]) par_case(rows[r]);
		wr(8'h1E, 8'h01);
		link_case(8'h84, 0, 4);
		link_case(8'h84, 0, 0);
		link_case(8'h84, 1, 4);
		wr(8'h1D, 8'h00);
		link_case(8'h86, 2, 0);
		link_case(8'h86, 0, 4);
		link_case(8'h86, 1, 4);
		link_case(8'h82, 2, 4);
		wr(8'h1D, 8'h00);
		link_case(8'hC9, 4, 8);
		link_case(8'hC9, 5, 8);
		link_case(8'h85, 4, 4);
		link_case(8'h83, 4, 0);
		link_case(8'h83, 5, 8);
		wr(8'h1C, 8'hFF);
		rd(8'h1C, 8'h3F);
		wr(8'h1D, 8'hA5);
		rd(8'h1D, 8'hA5);
		wr(8'h1E, 8'hFF);
		rd(8'h1E, 8'h07);
		wr(8'h1F, 8'hFF);
		rd(8'h1F, 8'h00);
		@(negedge clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		rd(8'h1C, 8'h00);
		rd(8'h1D, 8'h00);
		rd(8'h1E, 8'h00);
		tally_and_finish();
	end

	// Guard against a hang anywhere in the sequence
	initial begin
		#500000;
		errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
